// ### rtl/amp_power_id_regs.sv
`timescale 1ns/10ps
`include "amp_power_id_regs.svh"

// Contract
// - Identification register returns fixed code.
// - Power bits 7:2 are threshold top, reset ones.
// - Samples limited to programmed threshold magnitude.
// - Power bit 1 requests sleep, resets zero.
// - Sleep ramps volume down, then stage hi-z.
// - Asleep, other blocks stay ready to resume.
// - Shutdown when bit 0 low or pin low.
// - Power bit 0 resets one; zero requests shutdown.
// - Shutdown keeps bus working and registers intact.
// - Power-on reset loads all register defaults.
module amp_power_id_regs
  import amp_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda,
  output logic o_sda_oe,
  input wire logic i_shutdown_not_pin,
  input wire logic signed [23:0] i_sample,
  input wire logic i_sample_valid,
  output logic signed [23:0] o_dac_sample,
  output logic o_dac_valid,
  output logic o_stage_enable,
  output logic o_core_awake,
  output logic o_shutdown,
  output logic o_sleep,
  output logic o_dc_block_bypass,
  output logic o_slot_choice_source,
  output logic o_rate_single_double,
  output logic [2:0] o_serial_audio_format
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers.

  logic [2:0] sync1_ff; // First stage of scl, sda, shutdown pin.
  logic [2:0] sync2_ff; // Second stage.
  logic [2:0] sync3_ff; // Third stage.
  logic [2:0] pin_ff; // Filtered pin levels.
  logic scl_q_ff; // Filtered scl one cycle ago.
  logic sda_q_ff; // Filtered sda one cycle ago.
  logic scl_f; // Filtered scl.
  logic sda_f; // Filtered sda.
  logic sd_pin_f; // Filtered shutdown pin, low means shut down.

  // Three flops per pin; a level is accepted once stages two and three agree,
  // which also rejects a single-cycle glitch on the bus lines.
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      sync1_ff <= 3'h7;
      sync2_ff <= 3'h7;
      sync3_ff <= 3'h7;
      pin_ff <= 3'h7;
    end else begin
      sync1_ff <= {i_shutdown_not_pin, i_sda, i_scl};
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
      for (int i = 0; i < 3; i++) begin
        if (sync2_ff[i] == sync3_ff[i]) begin
          pin_ff[i] <= sync3_ff[i];
        end
      end
    end
  end
  assign scl_f = pin_ff[0];
  assign sda_f = pin_ff[1];
  assign sd_pin_f = pin_ff[2];

  // Delayed copies for edge and condition detection.
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      scl_q_ff <= 1'b1;
      sda_q_ff <= 1'b1;
    end else begin
      scl_q_ff <= scl_f;
      sda_q_ff <= sda_f;
    end
  end

  logic bus_start; // Data falls while clock high.
  logic bus_stop; // Data rises while clock high.
  logic scl_rise; // Clock rising edge.
  logic scl_fall; // Clock falling edge.
  assign bus_start = scl_f && scl_q_ff && sda_q_ff && !sda_f;
  assign bus_stop = scl_f && scl_q_ff && !sda_q_ff && sda_f;
  assign scl_rise = scl_f && !scl_q_ff;
  assign scl_fall = !scl_f && scl_q_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Register storage.

  power_control_t power_ff; // Power control register.
  digital_control_one_t dig1_ff; // Digital control one register.
  logic [7:0] ptr_ff; // Register pointer.
  logic wr_en; // A data byte has been received for ptr_ff.
  logic [7:0] rd_byte; // Register value at ptr_ff.
  logic [7:0] shift_ff; // Serial shift register.

  // Read decode; unmapped offsets answer zero.
  function automatic logic [7:0] read_reg(input logic [7:0] off,
                                          input power_control_t pc,
                                          input digital_control_one_t d1);
    case (off)
      `CHIP_ID_OFF: read_reg = `CHIP_ID_CODE;
      `POWER_CTRL_OFF: read_reg = pc;
      `DIG_CTRL1_OFF: read_reg = d1;
      default: read_reg = `UNMAPPED_DATA;
    endcase
  endfunction
  assign rd_byte = read_reg(ptr_ff, power_ff, dig1_ff);

  // Only power-on reset and bus writes touch the registers; shutdown leaves them alone.
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      power_ff <= `POWER_CTRL_RESET;
      dig1_ff <= `DIG_CTRL1_RESET;
    end else if (wr_en) begin
      case (ptr_ff)
        `POWER_CTRL_OFF: power_ff <= shift_ff;
        `DIG_CTRL1_OFF: dig1_ff <= shift_ff;
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial control port engine.

  bus_state_t state_ff; // Port state.
  logic [3:0] cnt_ff; // Bits moved in the present byte.
  logic rw_ff; // Transfer direction, one reads.
  logic ptr_pending_ff; // Next written byte is the pointer.
  logic ack_ok_ff; // Host acknowledged the last read byte.

  assign wr_en = (state_ff == ST_WRITE) && scl_fall && (cnt_ff == `BYTE_BITS) &&
                 !ptr_pending_ff;

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      state_ff <= ST_IDLE;
      cnt_ff <= 4'h0;
      shift_ff <= 8'h00;
      ptr_ff <= `CHIP_ID_OFF;
      rw_ff <= 1'b0;
      ptr_pending_ff <= 1'b0;
      ack_ok_ff <= 1'b0;
      o_sda_oe <= 1'b0;
    end else if (bus_start) begin
      // A repeated start restarts address reception at any point.
      state_ff <= ST_ADDR;
      cnt_ff <= 4'h0;
      o_sda_oe <= 1'b0;
    end else if (bus_stop) begin
      state_ff <= ST_IDLE;
      o_sda_oe <= 1'b0;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          o_sda_oe <= 1'b0;
        end
        ST_ADDR, ST_WRITE: begin
          // Bits are sampled on the rising clock and acknowledged on the fall.
          if (scl_rise && cnt_ff != `BYTE_BITS) begin
            shift_ff <= {shift_ff[6:0], sda_f};
            cnt_ff <= cnt_ff + 4'h1;
          end else if (scl_fall && cnt_ff == `BYTE_BITS) begin
            if (state_ff == ST_WRITE) begin
              state_ff <= ST_WRITE_ACK;
              o_sda_oe <= 1'b1;
              ptr_pending_ff <= 1'b0;
              ptr_ff <= ptr_pending_ff ? shift_ff : ptr_ff + 8'h01;
            end else if (shift_ff[7:1] == `DEV_BUS_ADDR) begin
              state_ff <= ST_ADDR_ACK;
              o_sda_oe <= 1'b1;
              rw_ff <= shift_ff[0];
              ptr_pending_ff <= !shift_ff[0];
            end else begin
              // Another device is addressed; stay off the bus.
              state_ff <= ST_IDLE;
            end
          end
        end
        ST_ADDR_ACK: begin
          if (scl_fall) begin
            cnt_ff <= 4'h0;
            if (rw_ff) begin
              state_ff <= ST_READ;
              shift_ff <= rd_byte;
              o_sda_oe <= !rd_byte[7];
            end else begin
              state_ff <= ST_WRITE;
              o_sda_oe <= 1'b0;
            end
          end
        end
        ST_WRITE_ACK: begin
          if (scl_fall) begin
            state_ff <= ST_WRITE;
            cnt_ff <= 4'h0;
            o_sda_oe <= 1'b0;
          end
        end
        ST_READ: begin
          if (scl_fall) begin
            if (cnt_ff == `LAST_READ_BIT) begin
              state_ff <= ST_READ_ACK;
              o_sda_oe <= 1'b0;
              ptr_ff <= ptr_ff + 8'h01;
            end else begin
              cnt_ff <= cnt_ff + 4'h1;
              shift_ff <= {shift_ff[6:0], 1'b0};
              o_sda_oe <= !shift_ff[6];
            end
          end
        end
        ST_READ_ACK: begin
          if (scl_rise) begin
            ack_ok_ff <= !sda_f;
          end else if (scl_fall) begin
            if (ack_ok_ff) begin
              state_ff <= ST_READ;
              cnt_ff <= 4'h0;
              shift_ff <= rd_byte;
              o_sda_oe <= !rd_byte[7];
            end else begin
              state_ff <= ST_IDLE;
            end
          end
        end
        default: begin
          state_ff <= ST_IDLE;
          o_sda_oe <= 1'b0;
        end
      endcase
    end
  end

  // Open-drain: the pin is only ever pulled low.
  assign o_sda = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Mode control and audio path.

  assign o_shutdown = !power_ff.shutdown_not || !sd_pin_f;
  assign o_sleep = power_ff.sleep_req;
  assign o_dc_block_bypass = dig1_ff.dc_block_bypass;
  assign o_slot_choice_source = dig1_ff.slot_choice_source;
  assign o_rate_single_double = dig1_ff.rate_single_double;
  assign o_serial_audio_format = dig1_ff.serial_audio_format;

  // The limiter and power sequencer; sleep keeps the core alive for restart.
  amp_limiter u_limiter (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_threshold({power_ff.sample_limit_threshold, `LIMIT_LOW_BITS}),
    .i_sleep(power_ff.sleep_req),
    .i_shutdown(o_shutdown),
    .i_sample(i_sample),
    .i_sample_valid(i_sample_valid),
    .o_dac_sample(o_dac_sample),
    .o_dac_valid(o_dac_valid),
    .o_stage_enable(o_stage_enable),
    .o_core_awake(o_core_awake)
  );

  ////////////////////////////////////////////////////////////////////////////

  a_id_read_code: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
    (state_ff == ST_ADDR_ACK) && scl_fall && rw_ff && (ptr_ff == `CHIP_ID_OFF)
    |=> shift_ff == `CHIP_ID_CODE)
    else $error("Identification read loaded the wrong code.");

  a_power_reset_val: assert property (
    @(posedge i_clock)
    !i_rst_n |=> power_ff.sample_limit_threshold == 6'h3F)
    else $error("Threshold top bits not all ones after reset.");

  a_sleep_reset: assert property (
    @(posedge i_clock)
    !i_rst_n |=> !power_ff.sleep_req && !o_sleep)
    else $error("Sleep request set after reset.");

  a_shutdown_bit_reset: assert property (
    @(posedge i_clock)
    !i_rst_n ##1 sd_pin_f |-> power_ff.shutdown_not && !o_shutdown)
    else $error("Shutdown asserted after reset with pin high.");

  a_pin_shutdown: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
    !sd_pin_f |-> o_shutdown ##1 !o_stage_enable)
    else $error("Low shutdown pin did not stop the stage.");

  a_regs_kept: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
    o_shutdown && !wr_en |=> $stable(power_ff) && $stable(dig1_ff))
    else $error("Register changed during shutdown without a write.");

  a_id_write_ignored: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
    wr_en && (ptr_ff == `CHIP_ID_OFF) |=> $stable(power_ff) && $stable(dig1_ff))
    else $error("Write to identification offset altered a register.");

  a_write_lands: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
    wr_en && (ptr_ff == `POWER_CTRL_OFF) |=> o_sleep == $past(shift_ff[1]))
    else $error("Sleep bit did not take the written value.");

endmodule

// ### rtl/amp_power_id_regs.svh
`ifndef AMP_POWER_ID_REGS_SVH
`define AMP_POWER_ID_REGS_SVH

// Register offsets on the serial control port.
`define CHIP_ID_OFF 8'h00
`define POWER_CTRL_OFF 8'h01
`define DIG_CTRL1_OFF 8'h02

// Identification code; the value is arbitrary.
`define CHIP_ID_CODE 8'h5A

// Reset values of the writable registers.
`define POWER_CTRL_RESET 8'hFD
`define DIG_CTRL1_RESET 8'h04

// Answer for an unmapped offset.
`define UNMAPPED_DATA 8'h00

// Low fourteen threshold bits, held elsewhere at their all-ones default.
`define LIMIT_LOW_BITS 14'h3FFF

// Seven-bit bus address of this device; the value is arbitrary.
`define DEV_BUS_ADDR 7'h6C

// Serial byte framing.
`define BYTE_BITS 4'h8
`define LAST_READ_BIT 4'h7

// Volume ramp: step time in ns and the clock period in ns.
`define RAMP_STEP_NS 100000
`define CLK_PERIOD_NS 100
`define RAMP_STEP_CYC (`RAMP_STEP_NS / `CLK_PERIOD_NS)
`define ATTEN_MAX 4'hF
`define ATTEN_MIN 4'h0

`endif

// ### rtl/amp_pkg.sv
package amp_pkg;

  // Power control register layout.
  typedef struct packed {
    logic [5:0] sample_limit_threshold;
    logic sleep_req;
    logic shutdown_not;
  } power_control_t;

  // Digital control one register layout.
  typedef struct packed {
    logic dc_block_bypass;
    logic slot_choice_source;
    logic [1:0] reserved;
    logic rate_single_double;
    logic [2:0] serial_audio_format;
  } digital_control_one_t;

  // Serial control port states.
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_ADDR = 7'h02,
    ST_ADDR_ACK = 7'h04,
    ST_WRITE = 7'h08,
    ST_WRITE_ACK = 7'h10,
    ST_READ = 7'h20,
    ST_READ_ACK = 7'h40
  } bus_state_t;

  // Amplifier power modes.
  typedef enum logic [4:0] {
    M_OFF = 5'h01,
    M_HIZ = 5'h02,
    M_RAMP_UP = 5'h04,
    M_PLAY = 5'h08,
    M_RAMP_DOWN = 5'h10
  } amp_mode_t;

endpackage

// ### rtl/amp_limiter.sv
`timescale 1ns/10ps
`include "amp_power_id_regs.svh"

module amp_limiter
  import amp_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic [19:0] i_threshold,
  input wire logic i_sleep,
  input wire logic i_shutdown,
  input wire logic signed [23:0] i_sample,
  input wire logic i_sample_valid,
  output logic signed [23:0] o_dac_sample,
  output logic o_dac_valid,
  output logic o_stage_enable,
  output logic o_core_awake
);

  amp_mode_t mode_ff; // Present power mode.
  logic [3:0] atten_ff; // Attenuation shift, zero is full volume.
  logic [15:0] tick_cnt_ff; // Ramp step timer.
  logic tick; // One ramp step has elapsed.
  logic [19:0] used_thr_ff; // Threshold applied to the present output word.

  // Saturate a sample to plus or minus the threshold magnitude.
  function automatic logic signed [23:0] clip(input logic signed [23:0] s,
                                              input logic [19:0] t);
    logic signed [23:0] tp;
    tp = signed'({4'h0, t});
    if (s > tp) begin
      clip = tp;
    end else if (s < -tp) begin
      clip = -tp;
    end else begin
      clip = s;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////

  // The ramp timer free-runs so each step lasts the same time.
  always_ff @(posedge i_clock) begin
    if (!i_rst_n || tick) begin
      tick_cnt_ff <= 16'h0000;
    end else begin
      tick_cnt_ff <= tick_cnt_ff + 16'h0001;
    end
  end
  assign tick = (tick_cnt_ff == 16'(`RAMP_STEP_CYC - 1));

  // Mode sequencing; shutdown always wins and drops the stage at once.
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      mode_ff <= M_OFF;
    end else begin
      case (mode_ff)
        M_OFF: begin
          if (!i_shutdown) begin
            mode_ff <= i_sleep ? M_HIZ : M_RAMP_UP;
          end
        end
        M_HIZ: begin
          if (i_shutdown) begin
            mode_ff <= M_OFF;
          end else if (!i_sleep) begin
            mode_ff <= M_RAMP_UP;
          end
        end
        M_RAMP_UP: begin
          if (i_shutdown) begin
            mode_ff <= M_OFF;
          end else if (i_sleep) begin
            mode_ff <= M_RAMP_DOWN;
          end else if (tick && atten_ff == `ATTEN_MIN) begin
            mode_ff <= M_PLAY;
          end
        end
        M_PLAY: begin
          if (i_shutdown) begin
            mode_ff <= M_OFF;
          end else if (i_sleep) begin
            mode_ff <= M_RAMP_DOWN;
          end
        end
        M_RAMP_DOWN: begin
          if (i_shutdown) begin
            mode_ff <= M_OFF;
          end else if (!i_sleep) begin
            mode_ff <= M_RAMP_UP;
          end else if (tick && atten_ff == `ATTEN_MAX) begin
            mode_ff <= M_HIZ;
          end
        end
        default: begin
          mode_ff <= M_OFF;
        end
      endcase
    end
  end

  // Attenuation walks one step per tick while ramping.
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      atten_ff <= `ATTEN_MAX;
    end else if (mode_ff == M_OFF || mode_ff == M_HIZ) begin
      atten_ff <= `ATTEN_MAX;
    end else if (tick && mode_ff == M_RAMP_UP && atten_ff != `ATTEN_MIN) begin
      atten_ff <= atten_ff - 4'h1;
    end else if (tick && mode_ff == M_RAMP_DOWN && atten_ff != `ATTEN_MAX) begin
      atten_ff <= atten_ff + 4'h1;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_dac_sample <= 24'sh000000;
      o_dac_valid <= 1'b0;
      used_thr_ff <= 20'h00000;
    end else begin
      o_dac_valid <= i_sample_valid && o_stage_enable;
      if (i_sample_valid) begin
        o_dac_sample <= clip(i_sample, i_threshold) >>> atten_ff;
        used_thr_ff <= i_threshold;
      end
    end
  end

  // The output stage only drives while playing or ramping.
  assign o_stage_enable = (mode_ff == M_RAMP_UP) || (mode_ff == M_PLAY) ||
                          (mode_ff == M_RAMP_DOWN);
  assign o_core_awake = (mode_ff != M_OFF);

  ////////////////////////////////////////////////////////////////////////////

  a_clip_bound: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
    o_dac_valid |-> (o_dac_sample <= signed'({4'h0, used_thr_ff})) &&
                    (o_dac_sample >= -signed'({4'h0, used_thr_ff})))
    else $error("Output sample exceeds limiter threshold.");

  a_ramp_before_hiz: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
    (mode_ff == M_RAMP_DOWN) ##1 (mode_ff == M_HIZ) |-> $past(atten_ff) == `ATTEN_MAX)
    else $error("Stage went hi-z before the ramp finished.");

  a_sleep_awake: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
    (i_sleep && !i_shutdown) [*2] |-> o_core_awake)
    else $error("Core powered down during sleep.");

  a_shutdown_stage: assert property (
    @(posedge i_clock) disable iff (!i_rst_n)
    i_shutdown |=> !o_stage_enable && !o_core_awake)
    else $error("Stage still live one cycle into shutdown.");

endmodule

// ### verification/i2c_host_model.sv
`timescale 1ns/10ps
`include "amp_power_id_regs.svh"

// Host on the serial control port. SDA is open drain with a pull-up.
module i2c_host_model (
  input wire logic i_clock,
  input wire logic i_dev_pull,
  output logic o_scl,
  output logic o_sda
);
  // High while the host pulls SDA low.
  logic host_pull;
  // Wired-AND of both pulls; a released line goes to the pull-up level.
  assign o_sda = !(host_pull || i_dev_pull);
  initial begin
    host_pull = 1'b0;
    o_scl = 1'b1;
  end
  //////////////////////////////////////////////////////////////////////
  // Six clocks a phase keeps each level well past the input filter.
  task automatic quarter();
    repeat (6) @(negedge i_clock);
  endtask
  // Start condition; from a low SCL this is a repeated start.
  task automatic start();
    host_pull = 1'b0;
    quarter();
    o_scl = 1'b1;
    quarter();
    host_pull = 1'b1;
    quarter();
    o_scl = 1'b0;
    quarter();
  endtask
  // Stop condition: SDA rises while SCL is high.
  task automatic stop();
    host_pull = 1'b1;
    quarter();
    o_scl = 1'b1;
    quarter();
    host_pull = 1'b0;
    quarter();
  endtask
  // Data is set while SCL is low and read in the middle of the high.
  task automatic bit_io(input logic b, output logic r);
    host_pull = !b;
    quarter();
    o_scl = 1'b1;
    quarter();
    r = o_sda;
    quarter();
    o_scl = 1'b0;
    quarter();
  endtask
  // Eight bits MSB first, then the ninth bit; last high releases SDA.
  task automatic byte_io(input logic [7:0] d, input logic last, output logic [7:0] q,
                         output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
      q[i] = r;
    end
    bit_io(last, r);
    ack = !r;
  endtask
  //////////////////////////////////////////////////////////////////////
  // One register write: address, pointer, data.
  task automatic write_reg(input logic [6:0] a, input logic [7:0] p, input logic [7:0] v,
                           output logic ok);
    logic [7:0] q;
    logic k1, k2, k3;
    start();
    byte_io({a, 1'b0}, 1'b1, q, k1);
    byte_io(p, 1'b1, q, k2);
    byte_io(v, 1'b1, q, k3);
    stop();
    ok = k1 && k2 && k3;
  endtask
  // Pointer set, repeated start, one byte read and ended by a NACK.
  task automatic read_reg(input logic [7:0] p, output logic [7:0] v, output logic ok);
    logic [7:0] q;
    logic k1, k2, k3, n;
    start();
    byte_io({`DEV_BUS_ADDR, 1'b0}, 1'b1, q, k1);
    byte_io(p, 1'b1, q, k2);
    start();
    byte_io({`DEV_BUS_ADDR, 1'b1}, 1'b1, q, k3);
    byte_io(8'hFF, 1'b1, v, n);
    stop();
    ok = k1 && k2 && k3;
  endtask
endmodule

// ### verification/amp_power_id_regs_tb.sv
`timescale 1ns/10ps
`include "amp_power_id_regs.svh"

module amp_power_id_regs_tb;
  // Bench-side copies of every port.
  logic clock, rst_n, scl, sda, sda_oe, pin_n, valid, sda_pin;
  logic dac_valid, stage, awake, shut, sleep, bypass, slot, rate;
  logic [2:0] fmt;
  logic signed [23:0] sample, dac;
  int num_errors = 0;
  int total_checks = 0;
  int cycles = 0;
  amp_power_id_regs dut_u (.i_clock(clock), .i_rst_n(rst_n), .i_scl(scl), .i_sda(sda),
    .o_sda(sda_pin), .o_sda_oe(sda_oe), .i_shutdown_not_pin(pin_n), .i_sample(sample),
    .i_sample_valid(valid), .o_dac_sample(dac), .o_dac_valid(dac_valid),
    .o_stage_enable(stage), .o_core_awake(awake), .o_shutdown(shut), .o_sleep(sleep),
    .o_dc_block_bypass(bypass), .o_slot_choice_source(slot),
    .o_rate_single_double(rate), .o_serial_audio_format(fmt));
  i2c_host_model host_u (.i_clock(clock), .i_dev_pull(sda_oe), .o_scl(scl), .o_sda(sda));
  initial clock = 1'b0;
  always #50 clock = ~clock;
  // The ramps dominate the run; anything past this ceiling is a hang.
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 100000) begin
      num_errors = num_errors + 1;
      $display("unexpected run length expected finish seen timeout");
      wrap_up();
    end
  end
  //////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Case inequality, so an unknown never passes.
  task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rd(input logic [7:0] p, input logic [7:0] exp, input string what);
    logic [7:0] v;
    logic ok;
    host_u.read_reg(p, v, ok);
    check("read ack", 24'h1, {23'h0, ok});
    check(what, {16'h0, exp}, {16'h0, v});
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] v);
    logic ok;
    host_u.write_reg(`DEV_BUS_ADDR, p, v, ok);
    check("write ack", 24'h1, {23'h0, ok});
  endtask
  // One-cycle sample pulse; the answer is settled at the next falling edge.
  task automatic play(input logic [23:0] s);
    @(negedge clock);
    sample = s;
    valid = 1'b1;
    @(negedge clock);
    valid = 1'b0;
  endtask
  // Expected limiter output at unity volume.
  function automatic logic [23:0] clip(input logic [23:0] s, input logic [5:0] top);
    logic signed [23:0] t;
    t = {4'h0, top, `LIMIT_LOW_BITS};
    if ($signed(s) > t) return t;
    if ($signed(s) < -t) return -t;
    return s;
  endfunction
  //////////////////////////////////////////////////////////////////////
  task automatic test_reset();
    rd(`CHIP_ID_OFF, `CHIP_ID_CODE, "id");
    rd(`POWER_CTRL_OFF, 8'hFD, "power");
    rd(`DIG_CTRL1_OFF, 8'h04, "digital");
    check("sleep", 24'h0, {23'h0, sleep});
    check("shutdown", 24'h0, {23'h0, shut});
    check("sda drive level", 24'h0, {23'h0, sda_pin});
    $display("test reset values done");
  endtask
  // The read-only code, an unmapped offset and a foreign bus address.
  task automatic test_id_ro();
    logic ok;
    wr(`CHIP_ID_OFF, 8'hA5);
    rd(`CHIP_ID_OFF, `CHIP_ID_CODE, "id after write");
    wr(8'h07, 8'h33);
    rd(8'h07, 8'h00, "unmapped");
    host_u.write_reg(7'h6D, `POWER_CTRL_OFF, 8'h00, ok);
    check("foreign ack", 24'h0, {23'h0, ok});
    rd(`POWER_CTRL_OFF, 8'hFD, "power kept");
    $display("test id read-only done");
  endtask
  // Acknowledged read of two bytes: the pointer runs on from the code.
  task automatic test_burst();
    logic [7:0] q, v0, v1;
    logic k0, k1, k2, k3;
    host_u.start();
    host_u.byte_io({`DEV_BUS_ADDR, 1'b0}, 1'b1, q, k0);
    host_u.byte_io(`CHIP_ID_OFF, 1'b1, q, k1);
    host_u.start();
    host_u.byte_io({`DEV_BUS_ADDR, 1'b1}, 1'b1, q, k2);
    host_u.byte_io(8'hFF, 1'b0, v0, k3);
    host_u.byte_io(8'hFF, 1'b1, v1, k3);
    host_u.stop();
    check("burst acks", 24'h7, {21'h0, k0, k1, k2});
    check("burst id", {16'h0, `CHIP_ID_CODE}, {16'h0, v0});
    check("burst power", 24'h0000FD, {16'h0, v1});
    $display("test burst read done");
  endtask
  task automatic test_digital();
    logic [7:0] v [2] = '{8'hCB, 8'h34};
    foreach (v[i]) begin
      wr(`DIG_CTRL1_OFF, v[i]);
      rd(`DIG_CTRL1_OFF, v[i], "digital");
      check("digital pins", {18'h0, v[i][7:6], v[i][3:0]}, {18'h0, bypass, slot, rate, fmt});
    end
    $display("test digital control done");
  endtask
  // Threshold top bits 000001 give a limit of 0x07FFF.
  task automatic test_limit();
    logic [23:0] s [6] = '{24'h7FFFFF, 24'h800000, 24'h012345, 24'hFFF000,
                           24'h007FFF, 24'hFF8000};
    wr(`POWER_CTRL_OFF, 8'h05);
    // Wait out the power-up ramp until a small sample passes unchanged.
    for (int n = 0; n < 300; n++) begin
      play(24'h000100);
      if (dac === 24'h000100) break;
      repeat (100) @(negedge clock);
    end
    foreach (s[i]) begin
      play(s[i]);
      check("dac valid", 24'h1, {23'h0, dac_valid});
      check("dac sample", clip(s[i], 6'h01), dac);
    end
    $display("test limiter done");
  endtask
  task automatic test_sleep();
    int n;
    wr(`POWER_CTRL_OFF, 8'h07);
    check("sleep", 24'h1, {23'h0, sleep});
    repeat (1500) @(negedge clock);
    check("stage in ramp", 24'h1, {23'h0, stage});
    play(24'h400000);
    check("volume lowered", 24'h1, {23'h0, $signed(dac) < 24'sh007FFF});
    for (n = 0; n < 18000 && stage === 1'b1; n++) @(negedge clock);
    check("stage hi-z", 24'h0, {23'h0, stage});
    check("core awake", 24'h1, {23'h0, awake});
    play(24'h000100);
    check("silent asleep", 24'h0, {23'h0, dac_valid});
    wr(`POWER_CTRL_OFF, 8'h05);
    for (n = 0; n < 2000 && stage !== 1'b1; n++) @(negedge clock);
    check("stage back", 24'h1, {23'h0, stage});
    $display("test sleep done");
  endtask
  // Register bit and pin each force shutdown; the bus keeps working.
  task automatic test_shutdown();
    wr(`DIG_CTRL1_OFF, 8'hCB);
    wr(`POWER_CTRL_OFF, 8'h04);
    check("shutdown", 24'h1, {23'h0, shut});
    repeat (4) @(negedge clock);
    check("core off", 24'h0, {23'h0, awake});
    check("stage off", 24'h0, {23'h0, stage});
    rd(`DIG_CTRL1_OFF, 8'hCB, "digital kept");
    rd(`POWER_CTRL_OFF, 8'h04, "power kept");
    wr(`POWER_CTRL_OFF, 8'h05);
    check("bit release", 24'h0, {23'h0, shut});
    pin_n = 1'b0;
    repeat (8) @(negedge clock);
    check("pin shutdown", 24'h1, {23'h0, shut});
    check("pin stage off", 24'h0, {23'h0, stage});
    rd(`POWER_CTRL_OFF, 8'h05, "power under pin");
    pin_n = 1'b1;
    repeat (8) @(negedge clock);
    check("pin release", 24'h0, {23'h0, shut});
    $display("test shutdown done");
  endtask
  // A second power-on reset reloads the defaults.
  task automatic test_por();
    rst_n = 1'b0;
    repeat (10) @(negedge clock);
    rst_n = 1'b1;
    repeat (2) @(negedge clock);
    rd(`POWER_CTRL_OFF, 8'hFD, "power after reset");
    rd(`DIG_CTRL1_OFF, 8'h04, "digital after reset");
    $display("test second reset done");
  endtask
  //////////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    pin_n = 1'b1;
    valid = 1'b0;
    sample = 24'h000000;
    repeat (10) @(negedge clock);
    rst_n = 1'b1;
    repeat (2) @(negedge clock);
    test_reset();
    test_burst();
    test_id_ro();
    test_digital();
    test_limit();
    test_sleep();
    test_shutdown();
    test_por();
    wrap_up();
  end
endmodule
